// >>> ext_bus_strobes.sv
// External memory bus master: strobes, space selects and wait states.
// Assumes the core gives one-cycle access requests on the same clock.
`include "ext_bus_defines.svh"
module ext_bus_strobes
    import ext_bus_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic REQ,
    input wire logic REQ_WRITE,
    input wire logic [1:0] REQ_SPACE,
    input wire logic [`ADDR_W-1:0] REQ_ADDR,
    input wire logic [`DATA_W-1:0] REQ_WDATA,
    input wire logic [`WAIT_W-1:0] WAIT_STATE_CONTROL,
    input wire logic READY,
    input wire logic [`DATA_W-1:0] DATA_IN,
    input wire logic EMULATION_FLOAT_PIN,
    input wire logic TEST_RESET,
    input wire logic EMULATION_PIN_ZERO,
    input wire logic QUAL_GPIO_MODE,
    input wire logic PORT_C_BIT0_OUT,
    input wire logic PORT_C_BIT0_DIR_OUT,
    output logic BUSY,
    output logic DONE,
    output logic [`DATA_W-1:0] RDATA,
    output logic [`ADDR_W-1:0] ADDR,
    output logic [`DATA_W-1:0] DATA_OUT,
    output logic DATA_OE_N,
    output logic READ_STROBE_N,
    output logic WRITE_STROBE_N,
    output logic EXTERNAL_ACCESS_STROBE_N,
    output logic PROGRAM_SPACE_SELECT_N,
    output logic DATA_SPACE_SELECT_N,
    output logic IO_SPACE_SELECT_N,
    output logic READ_WRITE,
    output logic WRITE_READ,
    output logic STROBE_OE_N,
    output logic PORT_C_BIT0_OE_N
);

    ////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers
    logic [1:0] rst_sync_r;
    logic rst_n;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // Two stages for each asynchronous pin: ready, float, test reset, emulation_pin_zero
    logic [3:0] pin_s1_r;
    logic [3:0] pin_s2_r;
    logic [3:0] pin_raw;
    assign pin_raw = {READY, EMULATION_FLOAT_PIN, TEST_RESET,
                      EMULATION_PIN_ZERO};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
            always_ff @(posedge CLK or negedge rst_n) begin
                if (!rst_n) begin
                    pin_s1_r[gi] <= (gi == 3) ? 1'b1 : 1'b0;
                    pin_s2_r[gi] <= (gi == 3) ? 1'b1 : 1'b0;
                end else begin
                    pin_s1_r[gi] <= pin_raw[gi];
                    pin_s2_r[gi] <= pin_s1_r[gi];
                end
            end
        end
    endgenerate
    logic ready_s;
    logic float_req;
    assign ready_s = pin_s2_r[3];
    assign float_req = !pin_s2_r[2] && !pin_s2_r[1] && pin_s2_r[0];

    ////////////////////////////////////////////////////////////////////
    // Bus cycle state machine
    bus_state_e state_r;
    bus_state_e state_nxt;
    logic write_r;
    logic write_nxt;
    space_t space_r;
    space_t space_nxt;
    logic [`ADDR_W-1:0] addr_r;
    logic [`ADDR_W-1:0] addr_nxt;
    logic [`DATA_W-1:0] wdata_r;
    logic [`DATA_W-1:0] wdata_nxt;
    logic [`DATA_W-1:0] rdata_r;
    logic [`DATA_W-1:0] rdata_nxt;
    logic use_ready_r;
    logic use_ready_nxt;
    logic done_r;
    logic done_nxt;
    logic wait_zero;
    logic wait_load;

    wait_counter u_wait (
        .clk(CLK),
        .rst_n(rst_n),
        .load(wait_load),
        .count_in(WAIT_STATE_CONTROL),
        .zero(wait_zero)
    );

    // Next state, captured request and completion
    always_comb begin
        state_nxt = state_r;
        write_nxt = write_r;
        space_nxt = space_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        rdata_nxt = rdata_r;
        use_ready_nxt = use_ready_r;
        done_nxt = 1'b0;
        wait_load = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (REQ) begin
                    write_nxt = REQ_WRITE;
                    space_nxt = REQ_SPACE;
                    addr_nxt = REQ_ADDR;
                    wdata_nxt = REQ_WDATA;
                    // Ready only counts with a software wait state
                    use_ready_nxt = (WAIT_STATE_CONTROL != 3'h0);
                    wait_load = 1'b1;
                    state_nxt = ST_SWAIT;
                end
            end
            ST_SWAIT: begin
                if (wait_zero) begin
                    if (use_ready_r) begin
                        state_nxt = ST_READY;
                    end else begin
                        state_nxt = ST_DONE;
                    end
                end
            end
            ST_READY: begin
                // Low ready adds one cycle, then it is sampled again
                if (ready_s) begin
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                if (!write_r) begin
                    rdata_nxt = DATA_IN;
                end
                done_nxt = 1'b1;
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Register the bus cycle state
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            write_r <= 1'b0;
            space_r <= `SPACE_PROG;
            addr_r <= 16'h0000;
            wdata_r <= 16'h0000;
            rdata_r <= 16'h0000;
            use_ready_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            write_r <= write_nxt;
            space_r <= space_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
            use_ready_r <= use_ready_nxt;
            done_r <= done_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin outputs, all registered; strobes and selects from the next bus state
    logic act_nxt;
    logic rd_n_nxt;
    logic wr_n_nxt;
    logic [2:0] sel_n_nxt;
    logic rw_nxt;
    logic wr_q_nxt;
    logic soe_n_nxt;
    logic pc_oe_n_nxt;
    logic rd_n_r;
    logic wr_n_r;
    logic external_access_strobe_n_r;
    logic [2:0] sel_n_r;
    logic rw_r;
    logic wr_q_r;
    logic soe_n_r;
    logic pc_oe_n_r;
    logic doe_n_r;

    // Strobe and qualifier values for the coming cycle
    always_comb begin
        act_nxt = (state_nxt != ST_IDLE);
        rd_n_nxt = !(act_nxt && !write_nxt);
        wr_n_nxt = !(act_nxt && write_nxt);
        sel_n_nxt = 3'h7;
        if (act_nxt) begin
            sel_n_nxt[space_nxt] = 1'b0;
        end
        rw_nxt = !(act_nxt && write_nxt);
        wr_q_nxt = QUAL_GPIO_MODE ? PORT_C_BIT0_OUT : !rw_nxt;
        soe_n_nxt = float_req;
        pc_oe_n_nxt = QUAL_GPIO_MODE ? !PORT_C_BIT0_DIR_OUT : 1'b0;
    end

    // Register the pins; GPIO starts as input
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            rd_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            external_access_strobe_n_r <= 1'b1;
            sel_n_r <= 3'h7;
            rw_r <= 1'b1;
            wr_q_r <= 1'b0;
            soe_n_r <= 1'b0;
            pc_oe_n_r <= 1'b1;
            doe_n_r <= 1'b1;
        end else begin
            rd_n_r <= rd_n_nxt;
            wr_n_r <= wr_n_nxt;
            external_access_strobe_n_r <= !act_nxt;
            sel_n_r <= sel_n_nxt;
            rw_r <= rw_nxt;
            wr_q_r <= wr_q_nxt;
            soe_n_r <= soe_n_nxt;
            pc_oe_n_r <= pc_oe_n_nxt;
            doe_n_r <= wr_n_nxt;
        end
    end

    logic busy_r;
    // Busy flag follows the bus cycle
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= act_nxt;
        end
    end

    assign BUSY = busy_r;
    assign DONE = done_r;
    assign RDATA = rdata_r;
    assign ADDR = addr_r;
    assign DATA_OUT = wdata_r;
    assign DATA_OE_N = doe_n_r;
    assign READ_STROBE_N = rd_n_r;
    assign WRITE_STROBE_N = wr_n_r;
    assign EXTERNAL_ACCESS_STROBE_N = external_access_strobe_n_r;
    assign PROGRAM_SPACE_SELECT_N = sel_n_r[0];
    assign DATA_SPACE_SELECT_N = sel_n_r[1];
    assign IO_SPACE_SELECT_N = sel_n_r[2];
    assign READ_WRITE = rw_r;
    assign WRITE_READ = wr_q_r;
    assign STROBE_OE_N = soe_n_r;
    assign PORT_C_BIT0_OE_N = pc_oe_n_r;
endmodule

// >>> ext_bus_defines.svh
// Constants for the external memory bus strobe block.
// Assumes inclusion by bare name from the package and the modules.
`ifndef EXT_BUS_DEFINES_SVH
`define EXT_BUS_DEFINES_SVH
`define DATA_W 16
`define ADDR_W 16
`define WAIT_W 3
`define SPACE_PROG 2'h0
`define SPACE_DATA 2'h1
`define SPACE_IO 2'h2
`endif

// >>> ext_bus_pkg.sv
// Types shared by the external bus strobe block.
// Assumes ext_bus_defines.svh is on the include path.
`include "ext_bus_defines.svh"
package ext_bus_pkg;
    typedef logic [1:0] space_t;
    typedef enum logic [1:0] {ST_IDLE, ST_SWAIT, ST_READY, ST_DONE} bus_state_e;
endpackage

// >>> wait_counter.sv
// Software wait-state down counter.
// Assumes a synchronised active-low reset copy from the top.
`include "ext_bus_defines.svh"
module wait_counter (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [`WAIT_W-1:0] count_in,
    output logic zero
);
    logic [`WAIT_W-1:0] cnt_r;
    logic [`WAIT_W-1:0] cnt_nxt;

    // Load on start, then count down to zero
    always_comb begin
        cnt_nxt = cnt_r;
        if (load) begin
            cnt_nxt = count_in;
        end else if (cnt_r != {`WAIT_W{1'b0}}) begin
            cnt_nxt = cnt_r - {{(`WAIT_W-1){1'b0}}, 1'b1};
        end
    end

    // Register the count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= {`WAIT_W{1'b0}};
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign zero = (cnt_r == {`WAIT_W{1'b0}});
endmodule

// >>> ext_bus_strobes_assertions.sv
// Port checker for the external bus strobe block.
// Assumes a bind onto ext_bus_strobes; watches its ports only.
`include "ext_bus_defines.svh"
module ext_bus_strobes_checker (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic REQ,
    input wire logic [`WAIT_W-1:0] WAIT_STATE_CONTROL,
    input wire logic EMULATION_FLOAT_PIN,
    input wire logic TEST_RESET,
    input wire logic EMULATION_PIN_ZERO,
    input wire logic QUAL_GPIO_MODE,
    input wire logic PORT_C_BIT0_OUT,
    input wire logic BUSY,
    input wire logic DONE,
    input wire logic DATA_OE_N,
    input wire logic READ_STROBE_N,
    input wire logic WRITE_STROBE_N,
    input wire logic EXTERNAL_ACCESS_STROBE_N,
    input wire logic PROGRAM_SPACE_SELECT_N,
    input wire logic DATA_SPACE_SELECT_N,
    input wire logic IO_SPACE_SELECT_N,
    input wire logic READ_WRITE,
    input wire logic WRITE_READ,
    input wire logic STROBE_OE_N,
    input wire logic PORT_C_BIT0_OE_N
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    ////////////////////////////////////////////////////////////////////////
    // Strobe and qualifier relations
    property p_inv; (!QUAL_GPIO_MODE)[*2] |-> WRITE_READ == !READ_WRITE;
    endproperty
    a_inv: assert property (p_inv) else $error("qualifier pair");
    property p_rd; !READ_STROBE_N |-> !EXTERNAL_ACCESS_STROBE_N && READ_WRITE;
    endproperty
    a_rd: assert property (p_rd) else $error("read strobe");
    property p_we; $fell(WRITE_STROBE_N) |-> !DATA_OE_N && !READ_WRITE;
    endproperty
    a_we: assert property (p_we) else $error("write strobe");
    property p_external_access_strobe; EXTERNAL_ACCESS_STROBE_N == !BUSY; endproperty
    a_external_access_strobe: assert property (p_external_access_strobe) else $error("access strobe");
    property p_end; $fell(BUSY) |-> DONE && EXTERNAL_ACCESS_STROBE_N;
    endproperty
    a_end: assert property (p_end) else $error("access end");
    property p_nowait; REQ && !BUSY && WAIT_STATE_CONTROL == 3'h0 |-> ##3 DONE;
    endproperty
    a_nowait: assert property (p_nowait) else $error("no wait");
    property p_float;
        (!EMULATION_FLOAT_PIN && !TEST_RESET && EMULATION_PIN_ZERO)[*8]
            |-> STROBE_OE_N;
    endproperty
    a_float: assert property (p_float) else $error("float");
    property p_rst; $rose(RESET_N) |-> PORT_C_BIT0_OE_N; endproperty
    a_rst: assert property (p_rst) else $error("gpio dir");
    property p_sel; $countones({PROGRAM_SPACE_SELECT_N, DATA_SPACE_SELECT_N,
        IO_SPACE_SELECT_N}) < 3 |-> !EXTERNAL_ACCESS_STROBE_N; endproperty
    a_sel: assert property (p_sel) else $error("select");
    property p_gpio; (QUAL_GPIO_MODE && $stable(PORT_C_BIT0_OUT))[*3]
        |-> WRITE_READ == PORT_C_BIT0_OUT; endproperty
    a_gpio: assert property (p_gpio) else $error("gpio value");
endmodule
bind ext_bus_strobes ext_bus_strobes_checker chk_u (.*);

// >>> ext_mem_model.sv
// Behavioural external memory on the strobe bus, four words deep.
// Assumes the bench sets stall: ready low cycles per access.
module ext_mem_model (
    input wire logic clk,
    input wire logic rd_n,
    input wire logic we_n,
    input wire logic external_access_strobe_n,
    input wire logic [15:0] addr,
    input wire logic [15:0] dout,
    input int stall,
    output logic ready,
    output logic [15:0] din
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [4];
    logic [15:0] last = 16'h0;
    logic external_access_strobe_q = 1'b1;
    int cnt = 0;
    // Hold ready low while not prepared, pull-up level otherwise
    assign ready = (cnt == 0);
    // Released data lines show the inverse of the last word
    assign din = rd_n ? ~last : mem[addr[1:0]];
    // Stall start on strobe fall, write capture, read history
    always @(posedge clk) begin
        external_access_strobe_q <= external_access_strobe_n;
        if (external_access_strobe_q && !external_access_strobe_n)
            cnt <= stall;
        else if (cnt > 0)
            cnt <= cnt - 1;
        if (!we_n)
            mem[addr[1:0]] <= dout;
        if (!rd_n)
            last <= mem[addr[1:0]];
    end
endmodule

// >>> test_external_memory_bus_strobes.sv
// Self-checking bench for the external bus strobe block.
// Assumes ext_mem_model answers on the far side of the bus.
module test_external_memory_bus_strobes;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [1:0] sp; logic [2:0] ws; logic [15:0] d;
        int el;} row_s;
    logic CLK = 0, RESET_N = 0, REQ = 0, REQ_WRITE = 0, READY;
    logic [1:0] REQ_SPACE = 0;
    logic [15:0] REQ_ADDR = 0, REQ_WDATA = 0, DATA_IN, RDATA, ADDR;
    logic [15:0] DATA_OUT;
    logic [2:0] WAIT_STATE_CONTROL = 0;
    logic EMULATION_FLOAT_PIN = 1, TEST_RESET = 0, EMULATION_PIN_ZERO = 0;
    logic QUAL_GPIO_MODE = 0, PORT_C_BIT0_OUT = 0, PORT_C_BIT0_DIR_OUT = 0;
    logic BUSY, DONE, DATA_OE_N, READ_STROBE_N, WRITE_STROBE_N;
    logic EXTERNAL_ACCESS_STROBE_N, PROGRAM_SPACE_SELECT_N, READ_WRITE;
    logic DATA_SPACE_SELECT_N, IO_SPACE_SELECT_N, WRITE_READ;
    logic STROBE_OE_N, PORT_C_BIT0_OE_N;
    int fail_count = 0, checks = 0, stall = 0, lat = 0;
    row_s rows [4] = '{'{2'h0, 3'h0, 16'hA5C3, 3}, '{2'h1, 3'h1, 16'h5A3C, 5},
        '{2'h2, 3'h2, 16'hFFFF, 0}, '{2'h3, 3'h7, 16'h0001, 0}};
    always #2 CLK = ~CLK;
    ext_bus_strobes dut_u (.*);
    ext_mem_model mem_u (.clk(CLK), .rd_n(READ_STROBE_N),
        .we_n(WRITE_STROBE_N), .external_access_strobe_n(EXTERNAL_ACCESS_STROBE_N),
        .addr(ADDR), .dout(DATA_OUT), .stall(stall), .ready(READY),
        .din(DATA_IN));
    ////////////////////////////////////////////////////////////////////////
    // Compare and closing report
    task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        checks++;
        if (s !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, s);
            fail_count++;
        end
    endtask
    task print_verdict;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // One bus access, strobes checked in its first cycle and idle again when DONE rises
    task acc(input logic w, input logic [1:0] sp, input logic [2:0] ws,
        input logic [15:0] a, input logic [15:0] d);
        @(posedge CLK);
        REQ <= 1'b1;
        REQ_WRITE <= w;
        REQ_SPACE <= sp;
        WAIT_STATE_CONTROL <= ws;
        REQ_ADDR <= a;
        REQ_WDATA <= d;
        @(posedge CLK);
        REQ <= 1'b0;
        #1;
        chk("strobes", {10'h0, w, !w, !w, w, !w, 1'b0}, {10'h0, READ_STROBE_N,
            WRITE_STROBE_N, READ_WRITE, WRITE_READ, DATA_OE_N,
            EXTERNAL_ACCESS_STROBE_N});
        chk("sel", {13'h0, ~(3'h4 >> sp)}, {13'h0, PROGRAM_SPACE_SELECT_N,
            DATA_SPACE_SELECT_N, IO_SPACE_SELECT_N});
        lat = 1;
        while (DONE !== 1'b1 && lat < 40) begin
            @(posedge CLK);
            #1;
            lat++;
        end
        if (lat >= 40) begin
            $display("BAD done expected 1 seen %b", DONE);
            fail_count++;
            print_verdict();
        end
        chk("idle", 16'h000F, {12'h0, READ_STROBE_N, WRITE_STROBE_N,
            READ_WRITE, EXTERNAL_ACCESS_STROBE_N});
        if (!w)
            chk("rdata", d, RDATA);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (15) @(posedge CLK);
        #1;
        chk("reset", 16'h003D, {10'h0, READ_STROBE_N, WRITE_STROBE_N,
            EXTERNAL_ACCESS_STROBE_N, READ_WRITE, WRITE_READ,
            PORT_C_BIT0_OE_N});
        @(posedge CLK);
        RESET_N <= 1'b1;
        repeat (3) @(posedge CLK);
        foreach (rows[i]) begin
            acc(1'b1, rows[i].sp, rows[i].ws, 16'(i), rows[i].d);
            if (rows[i].el > 0)
                chk("wlat", 16'(rows[i].el), 16'(lat));
            acc(1'b0, rows[i].sp, rows[i].ws, 16'(i), rows[i].d);
        end
        chk("pcoe", 16'h0, {15'h0, PORT_C_BIT0_OE_N});
        stall = 6;
        acc(1'b0, 2'h1, 3'h0, 16'h0, rows[0].d);
        chk("ignored", 16'h3, 16'(lat));
        acc(1'b0, 2'h1, 3'h1, 16'h1, rows[1].d);
        chk("stalled", 16'h1, {15'h0, lat > 5});
        stall = 0;
        @(posedge CLK);
        EMULATION_FLOAT_PIN <= 1'b0;
        EMULATION_PIN_ZERO <= 1'b1;
        repeat (8) @(posedge CLK);
        TEST_RESET <= 1'b1;
        #1;
        chk("float", 16'h1, {15'h0, STROBE_OE_N});
        repeat (8) @(posedge CLK);
        EMULATION_FLOAT_PIN <= 1'b1;
        QUAL_GPIO_MODE <= 1'b1;
        PORT_C_BIT0_OUT <= 1'b1;
        PORT_C_BIT0_DIR_OUT <= 1'b1;
        #1;
        chk("drive", 16'h0, {15'h0, STROBE_OE_N});
        repeat (4) @(posedge CLK);
        PORT_C_BIT0_OUT <= 1'b0;
        PORT_C_BIT0_DIR_OUT <= 1'b0;
        #1;
        chk("gpio", 16'h2, {14'h0, WRITE_READ, PORT_C_BIT0_OE_N});
        repeat (4) @(posedge CLK);
        #1;
        chk("gpio", 16'h1, {14'h0, WRITE_READ, PORT_C_BIT0_OE_N});
        print_verdict();
    end
endmodule
